// *** timer_regs.svh ***
// register indices, field positions, reset values and counts of the timer
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH
`define IDX_W 6
`define IDX_POWER 6'h10
`define IDX_OSC 6'h11
`define IDX_CTRL 6'h12
`define IDX_STAT 6'h13
`define IDX_CAP_HI 6'h14
`define IDX_CAP_LO 6'h15
`define IDX_CMP_HI 6'h16
`define IDX_CMP_LO 6'h17
`define IDX_CNT_HI 6'h18
`define IDX_CNT_LO 6'h19
`define IDX_ALT_HI 6'h1a
`define IDX_ALT_LO 6'h1b
`define BIT_CAP_IE 7
`define BIT_CMP_IE 6
`define BIT_OVF_IE 5
`define BIT_EDGE 1
`define BIT_LEVEL 0
`define BIT_CAP_F 7
`define BIT_CMP_F 6
`define BIT_OVF_F 5
`define BIT_PIN_OSC 4
`define BIT_EXT_CLK 3
`define BIT_SHORT 2
`define BIT_STOP 0
`define BIT_WAKING 1
`define FLAG_MSB 7
`define FLAG_LSB 5
`define CNT_RST 16'hfffc
`define CNT_ALL1 16'hffff
`define PRE_LAST 2'h3
`define PRE_RST 2'h0
`define WAKE_LONG 12'd4064
`define WAKE_SHORT 12'd2
`define WAKE_DONE 12'd1
`define WAKE_RST 12'd0
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h00000000
`endif

// *** timer_pkg.sv ***
// types shared by the timer control and status logic
package timer_pkg;
	typedef enum logic [1:0] {
		pw_run = 2'b00,
		pw_stopped = 2'b01,
		pw_waking = 2'b10
	} power_state_t;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] count_t;
	typedef logic [2:0] flags_t;
endpackage

// *** timer_ctrl.sv ***
// timer control, status flags, clock select and stop handling on apb
`timescale 1ns/10ps
`include "timer_regs.svh"

module timer_ctrl #(
	parameter bit RC_OSC = 1'b0
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_in_pin,
	input wire logic ext_irq,
	output logic compare_out_pin,
	output logic compare_out_en,
	output logic timer_osc_out,
	output logic timer_osc_en,
	output logic timer_irq,
	output logic stopped
);
	timer_pkg::power_state_t pw_r;
	timer_pkg::count_t cnt_r;
	timer_pkg::count_t cnt_inc;
	timer_pkg::count_t cap_r;
	timer_pkg::count_t cmp_r;
	timer_pkg::flags_t flag_r;
	timer_pkg::flags_t arm_r;
	timer_pkg::flags_t set_ev;
	timer_pkg::flags_t clr_ev;
	timer_pkg::flags_t ien_r;
	timer_pkg::byte_t rdata;
	timer_pkg::byte_t cnt_buf_r;
	timer_pkg::byte_t snap_lo_r;
	logic [`IDX_W-1:0] idx;
	logic [11:0] wake_r;
	logic [1:0] pre_r;
	logic edge_sel_r;
	logic next_level_r;
	logic pin_osc_r;
	logic ext_clk_r;
	logic short_r;
	logic pin_q_r;
	logic pin_d_r;
	logic cnt_lock_r;
	logic cap_lock_r;
	logic cmp_inh_r;
	logic acc_en;
	logic done;
	logic rd;
	logic wr;
	logic hit;
	logic run;
	logic rise;
	logic fall;
	logic step;
	logic tick;
	logic cap_ev;
	logic match;
	logic ovf;

	assign idx = paddr[`IDX_W+1:2];
	// first access cycle loads read data, second completes the transfer
	assign acc_en = psel & penable & ~pready;
	assign done = psel & penable & pready;
	assign rd = done & ~pwrite & ~pslverr;
	assign wr = done & pwrite & ~pslverr;
	assign run = (pw_r == timer_pkg::pw_run);
	assign rise = pin_q_r & ~pin_d_r;
	assign fall = ~pin_q_r & pin_d_r;
	assign cnt_inc = cnt_r + 16'h0001;

	always_comb
	begin
		hit = (paddr[1:0] == 2'h0) && (paddr[7:2] >= `IDX_POWER)
			&& (paddr[7:2] <= `IDX_ALT_LO);
	end

	// while running, prescaler advances every cycle or on each rising pin edge
	always_comb
	begin
		step = run & (ext_clk_r ? rise : 1'b1);
		tick = step & (pre_r == `PRE_LAST);
		cap_ev = run & ~cap_lock_r & (edge_sel_r ? rise : fall);
		match = tick & ~cmp_inh_r & (cnt_inc == cmp_r);
		ovf = tick & (cnt_r == `CNT_ALL1);
	end

	always_comb
	begin
		set_ev = {cap_ev, match, ovf};
		clr_ev = 3'b000;
		if (done && !pslverr && idx == `IDX_CAP_LO)
		begin
			clr_ev[2] = arm_r[2];
		end
		if (done && !pslverr && idx == `IDX_CMP_LO)
		begin
			clr_ev[1] = arm_r[1];
		end
		if (rd && idx == `IDX_CNT_LO)
		begin
			clr_ev[0] = arm_r[0];
		end
	end

	always_comb
	begin
		rdata = `BYTE_ZERO;
		unique case (idx)
			`IDX_POWER:
			begin
				rdata[`BIT_STOP] = (pw_r == timer_pkg::pw_stopped);
				rdata[`BIT_WAKING] = (pw_r == timer_pkg::pw_waking);
			end
			`IDX_OSC:
			begin
				rdata[`BIT_PIN_OSC] = pin_osc_r;
				rdata[`BIT_EXT_CLK] = ext_clk_r;
				rdata[`BIT_SHORT] = short_r;
			end
			`IDX_CTRL:
			begin
				rdata[`FLAG_MSB:`FLAG_LSB] = ien_r;
				rdata[`BIT_EDGE] = edge_sel_r;
				rdata[`BIT_LEVEL] = next_level_r;
			end
			`IDX_STAT:
			begin
				rdata[`FLAG_MSB:`FLAG_LSB] = flag_r;
			end
			`IDX_CAP_HI:
			begin
				rdata = cap_r[15:8];
			end
			`IDX_CAP_LO:
			begin
				rdata = cap_r[7:0];
			end
			`IDX_CMP_HI:
			begin
				rdata = cmp_r[15:8];
			end
			`IDX_CMP_LO:
			begin
				rdata = cmp_r[7:0];
			end
			`IDX_CNT_HI, `IDX_ALT_HI:
			begin
				rdata = cnt_r[15:8];
			end
			`IDX_CNT_LO, `IDX_ALT_LO:
			begin
				rdata = cnt_lock_r ? cnt_buf_r : cnt_r[7:0];
			end
			default:
			begin
				rdata = `BYTE_ZERO;
			end
		endcase
	end

	// apb answer: one wait state, error on unmapped or misaligned address
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `WORD_ZERO;
			snap_lo_r <= `BYTE_ZERO;
		end
		else
		begin
			pready <= acc_en;
			pslverr <= acc_en & ~hit;
			if (acc_en)
			begin
				prdata <= {24'h000000, hit ? rdata : `BYTE_ZERO};
				snap_lo_r <= cnt_r[7:0];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ien_r <= 3'b000;
			next_level_r <= 1'b0;
		end
		else if (wr && idx == `IDX_CTRL)
		begin
			ien_r <= pwdata[`FLAG_MSB:`FLAG_LSB];
			next_level_r <= pwdata[`BIT_LEVEL];
		end
	end

	// edge select survives the system reset, only power-up defines it
	always_ff @(posedge ref_clk or posedge por_rst)
	begin
		if (por_rst)
		begin
			edge_sel_r <= 1'b0;
		end
		else if (wr && idx == `IDX_CTRL)
		begin
			edge_sel_r <= pwdata[`BIT_EDGE];
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_osc_r <= 1'b0;
			ext_clk_r <= 1'b0;
			short_r <= 1'b0;
		end
		else if (wr && idx == `IDX_OSC)
		begin
			// no settle check: software owns the oscillator wait
			pin_osc_r <= pwdata[`BIT_PIN_OSC];
			ext_clk_r <= pwdata[`BIT_EXT_CLK];
			short_r <= pwdata[`BIT_SHORT];
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_q_r <= 1'b0;
			pin_d_r <= 1'b0;
		end
		else
		begin
			pin_q_r <= capture_in_pin;
			pin_d_r <= pin_q_r;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pre_r <= `PRE_RST;
			cnt_r <= `CNT_RST;
		end
		else if (step)
		begin
			pre_r <= pre_r + 2'h1;
			if (tick)
			begin
				cnt_r <= cnt_inc;
			end
		end
	end

	// a high byte read freezes the low byte until the low byte is read
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_lock_r <= 1'b0;
			cnt_buf_r <= `BYTE_ZERO;
		end
		else if (rd && (idx == `IDX_CNT_HI || idx == `IDX_ALT_HI))
		begin
			if (!cnt_lock_r)
			begin
				cnt_buf_r <= snap_lo_r;
			end
			cnt_lock_r <= 1'b1;
		end
		else if (rd && (idx == `IDX_CNT_LO || idx == `IDX_ALT_LO))
		begin
			cnt_lock_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge por_rst)
	begin
		if (por_rst)
		begin
			cap_r <= 16'h0000;
		end
		else if (cap_ev)
		begin
			cap_r <= cnt_inc;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cap_lock_r <= 1'b0;
		end
		else if (rd && idx == `IDX_CAP_HI)
		begin
			cap_lock_r <= 1'b1;
		end
		else if (rd && idx == `IDX_CAP_LO)
		begin
			cap_lock_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge por_rst)
	begin
		if (por_rst)
		begin
			cmp_r <= 16'h0000;
		end
		else if (wr && idx == `IDX_CMP_HI)
		begin
			cmp_r[15:8] <= pwdata[7:0];
		end
		else if (wr && idx == `IDX_CMP_LO)
		begin
			cmp_r[7:0] <= pwdata[7:0];
		end
	end

	// high byte write holds off matches until the low byte follows
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cmp_inh_r <= 1'b0;
		end
		else if (wr && idx == `IDX_CMP_HI)
		begin
			cmp_inh_r <= 1'b1;
		end
		else if (wr && idx == `IDX_CMP_LO)
		begin
			cmp_inh_r <= 1'b0;
		end
	end

	// flags see only power-up reset; a set in a clearing cycle wins
	always_ff @(posedge ref_clk or posedge por_rst)
	begin
		if (por_rst)
		begin
			flag_r <= 3'b000;
		end
		else
		begin
			flag_r <= set_ev | (flag_r & ~clr_ev);
		end
	end

	// arming snapshots the flags at a status access, either direction
	always_ff @(posedge ref_clk or posedge por_rst)
	begin
		if (por_rst)
		begin
			arm_r <= 3'b000;
		end
		else if (done && !pslverr && idx == `IDX_STAT)
		begin
			arm_r <= flag_r;
		end
		else
		begin
			arm_r <= arm_r & ~clr_ev;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			compare_out_pin <= 1'b0;
		end
		else if (match)
		begin
			compare_out_pin <= next_level_r;
		end
	end

	// crystal mode: inverting amplifier from the capture pin to the other
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timer_osc_out <= 1'b0;
			timer_osc_en <= 1'b0;
			compare_out_en <= 1'b1;
		end
		else
		begin
			timer_osc_out <= ~capture_in_pin;
			timer_osc_en <= pin_osc_r;
			compare_out_en <= ~pin_osc_r;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timer_irq <= 1'b0;
		end
		else
		begin
			timer_irq <= |(flag_r & ien_r);
		end
	end

	// wait mode needs nothing: the timer simply keeps running
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pw_r <= timer_pkg::pw_run;
			wake_r <= `WAKE_RST;
		end
		else
		begin
			unique case (pw_r)
				timer_pkg::pw_run:
				begin
					if (wr && idx == `IDX_POWER && pwdata[`BIT_STOP])
					begin
						pw_r <= timer_pkg::pw_stopped;
					end
				end
				timer_pkg::pw_stopped:
				begin
					if (ext_irq)
					begin
						pw_r <= timer_pkg::pw_waking;
						if (RC_OSC || short_r)
						begin
							wake_r <= `WAKE_SHORT;
						end
						else
						begin
							wake_r <= `WAKE_LONG;
						end
					end
				end
				timer_pkg::pw_waking:
				begin
					if (wake_r == `WAKE_DONE)
					begin
						pw_r <= timer_pkg::pw_run;
						wake_r <= `WAKE_RST;
					end
					else
					begin
						wake_r <= wake_r - 12'd1;
					end
				end
				default:
				begin
					pw_r <= timer_pkg::pw_run;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stopped <= 1'b0;
		end
		else
		begin
			stopped <= ~run;
		end
	end
endmodule

// *** timer_ctrl_checker.sv ***
// port assertions for the timer control block
`timescale 1ns/10ps
module timer_ctrl_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic capture_in_pin,
	input wire logic compare_out_en,
	input wire logic timer_osc_out,
	input wire logic timer_osc_en,
	input wire logic timer_irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic done;
	logic bad;
	assign done = psel && penable && pready;
	assign bad = paddr[1:0] != 2'h0 || paddr[7:2] < 6'h10
		|| paddr[7:2] > 6'h1b;
	sequence first_access;
		psel && penable && !$past(penable);
	endsequence
	sequence one_wait;
		!pready ##1 pready;
	endsequence
	a_one_wait_state: assert property (first_access |-> one_wait)
		else $error("access did not end after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_bad_refused: assert property (done && bad |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_stat_low_zero: assert property (done && !pwrite && paddr == 8'h4c
		|-> prdata[4:0] == 5'h0 && !pslverr)
		else $error("status low bits not zero");
	a_ctrl_mid_zero: assert property (done && !pwrite && paddr == 8'h48
		|-> prdata[4:2] == 3'h0)
		else $error("control bits four to two not zero");
	a_irq_off_enables: assert property (done && pwrite && paddr == 8'h48
		&& pwdata[7:5] == 3'h0 |=> ##1 !timer_irq)
		else $error("interrupt with all enables clear");
	a_osc_en_follow: assert property (done && pwrite && paddr == 8'h44
		|=> ##1 timer_osc_en == $past(pwdata[4], 2))
		else $error("oscillator enable did not follow write");
	a_pins_swap: assert property (timer_osc_en == !compare_out_en)
		else $error("compare pin driven while amplifier on");
	a_amp_inverts: assert property (timer_osc_en && $past(timer_osc_en)
		|-> timer_osc_out == !$past(capture_in_pin))
		else $error("amplifier output not inverse of input");
endmodule
bind timer_ctrl timer_ctrl_checker chk_i (.ref_clk, .sys_rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .capture_in_pin,
	.compare_out_en, .timer_osc_out, .timer_osc_en, .timer_irq);

// *** pin_side_model.sv ***
// capture pin and external interrupt line as seen from outside
`timescale 1ns/10ps
module pin_side_model (
	input wire logic ref_clk,
	output logic capture_in_pin,
	output logic ext_irq
);
	initial
	begin
		capture_in_pin = 1'b0;
		ext_irq = 1'b0;
	end
	// each level is held past the two stage synchroniser so no edge is lost
	task automatic drive_pin(input logic lvl);
		@(posedge ref_clk);
		capture_in_pin <= lvl;
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic wake_pulse();
		@(posedge ref_clk);
		ext_irq <= 1'b1;
		repeat (2) @(posedge ref_clk);
		ext_irq <= 1'b0;
	endtask
endmodule

// *** test_timer_ctrl.sv ***
// self-checking bench for the timer control and status block
`timescale 1ns/10ps
`include "timer_regs.svh"
module test_timer_ctrl;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic por_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic [7:0] hi;
	logic pready, pslverr, capture_in_pin, ext_irq, compare_out_pin, e;
	logic compare_out_en, timer_osc_out, timer_osc_en, timer_irq, stopped;
	integer miscompares = 0;
	integer checks_done = 0;
	timer_ctrl dut (.ref_clk, .sys_rst, .por_rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .capture_in_pin, .ext_irq,
		.compare_out_pin, .compare_out_en, .timer_osc_out, .timer_osc_en,
		.timer_irq, .stopped);
	pin_side_model ps (.ref_clk, .capture_in_pin, .ext_irq);
	always #10 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one idle cycle between transfers keeps every signal single-assigned
	task automatic xfer(input logic w, input logic [5:0] idx,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			chk(32'h0, 32'h1);
			summarize();
		end
	endtask
	task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(q, exp);
	endtask
	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d);
	endtask
	task automatic settle();
		repeat (2) @(negedge ref_clk);
	endtask
	initial
	begin
		int n;
		int dly;
		logic [15:0] c;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
		repeat (24) @(posedge ref_clk);
		rd(`IDX_CTRL, 32'h0);
		rd(`IDX_OSC, 32'h0);
		chk(32'(compare_out_pin), 32'h0);
		// rollover and a match at zero both happened since reset
		rd(`IDX_STAT, 32'h60);
		wr(`IDX_CTRL, 32'hff);
		rd(`IDX_CTRL, 32'he3);
		settle();
		chk(32'(timer_irq), 32'h1);
		wr(`IDX_CTRL, 32'h0);
		settle();
		chk(32'(timer_irq), 32'h0);
		xfer(1'b1, 6'h00, 32'hff);
		chk(32'(e), 32'h1);
		wr(`IDX_STAT, 32'h0);
		xfer(1'b0, `IDX_ALT_LO, 32'h0);
		rd(`IDX_STAT, 32'h60);
		xfer(1'b0, `IDX_CNT_LO, 32'h0);
		rd(`IDX_STAT, 32'h40);
		xfer(1'b0, `IDX_CNT_HI, 32'h0);
		hi = q[7:0];
		xfer(1'b0, `IDX_CNT_LO, 32'h0);
		c = {hi, q[7:0]} + 16'h40;
		wr(`IDX_CMP_HI, {24'h0, c[15:8]});
		rd(`IDX_STAT, 32'h40);
		wr(`IDX_CMP_LO, {24'h0, c[7:0]});
		rd(`IDX_STAT, 32'h0);
		wr(`IDX_CTRL, 32'h41);
		settle();
		chk(32'(compare_out_pin), 32'h0);
		n = 0;
		while (compare_out_pin !== 1'b1 && n < 400)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(compare_out_pin), 32'h1);
		if (n >= 400)
			summarize();
		settle();
		chk(32'(timer_irq), 32'h1);
		rd(`IDX_STAT, 32'h40);
		wr(`IDX_CMP_LO, {24'h0, c[7:0]});
		rd(`IDX_STAT, 32'h0);
		wr(`IDX_CTRL, 32'h82);
		ps.drive_pin(1'b1);
		settle();
		chk(32'(timer_irq), 32'h1);
		rd(`IDX_STAT, 32'h80);
		xfer(1'b0, `IDX_CAP_HI, 32'h0);
		xfer(1'b0, `IDX_CAP_LO, 32'h0);
		rd(`IDX_STAT, 32'h0);
		ps.drive_pin(1'b0);
		rd(`IDX_STAT, 32'h0);
		// that status read armed nothing, so the new capture must survive
		ps.drive_pin(1'b1);
		xfer(1'b0, `IDX_CAP_LO, 32'h0);
		rd(`IDX_STAT, 32'h80);
		wr(`IDX_OSC, 32'h10);
		rd(`IDX_OSC, 32'h10);
		ps.drive_pin(1'b1);
		ps.drive_pin(1'b0);
		settle();
		chk(32'(compare_out_en), 32'h0);
		// no crystal on the bench, so a short settle stands for the wait
		settle();
		wr(`IDX_OSC, 32'h18);
		xfer(1'b0, `IDX_CNT_HI, 32'h0);
		hi = q[7:0];
		xfer(1'b0, `IDX_CNT_LO, 32'h0);
		// eight pin rises give two counts whatever the prescaler phase
		c = {hi, q[7:0]} + 16'h2;
		repeat (8)
		begin
			ps.drive_pin(1'b1);
			ps.drive_pin(1'b0);
		end
		rd(`IDX_CNT_HI, {24'h0, c[15:8]});
		rd(`IDX_CNT_LO, {24'h0, c[7:0]});
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(`IDX_STAT, 32'h80);
		rd(`IDX_CTRL, 32'h2);
		rd(`IDX_OSC, 32'h0);
		chk(32'(compare_out_pin), 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			dly = i ? 4064 : 2;
			wr(`IDX_OSC, i ? 32'h0 : 32'h4);
			wr(`IDX_POWER, 32'h1);
			xfer(1'b0, `IDX_CNT_HI, 32'h0);
			rd(`IDX_ALT_HI, q);
			xfer(1'b0, `IDX_ALT_LO, 32'h0);
			repeat (20) @(posedge ref_clk);
			rd(`IDX_ALT_LO, q);
			chk(32'(stopped), 32'h1);
			fork
				ps.wake_pulse();
			join_none
			n = 0;
			do
			begin
				@(posedge ref_clk);
				n++;
			end
			while (stopped !== 1'b0 && n < 5000);
			chk(32'(n >= dly && n <= dly + 8), 32'h1);
			if (n >= 5000)
				summarize();
		end
		summarize();
	end
endmodule
